// file: src/ttm_monitor.sv
// Trail termination monitor with its source payload buffer
//
// Function
// [RULE_01] Source inserts an interleaved parity code and the local path identifier.
// [RULE_02] Source returns the count of parity violations found by the local sink.
// [RULE_03] Source returns the current local sink defect state as remote defect.
// [RULE_04] Sink watches errors, misconnection, near/far performance, server fail, loss.
// [RULE_05] Bit errors are found as parity code violations over each frame.
// [RULE_06] Received path identifier is compared with the expected one; mismatch is misconnection.
// [RULE_07] On any defect the passed signal becomes all ones and remote defect is sent; code does it for loss, server fail, mismatch, not far defect.
// [RULE_08] Every detected defect appears as a status output.
// [RULE_09] Near-end errored blocks are counted per one-second interval.
// [RULE_10] Far-end errored blocks from the received remote count are counted per second.
// [RULE_11] A second with any signal fail is a near-end defect second.
// [RULE_12] A second with a received remote defect is a far-end defect second.
// [RULE_13] Errored, severely errored and unavailable seconds derive from counts and flags.
// [RULE_14] Physical section mode monitors only signal loss, no overhead processing.
// [RULE_15] Counts and flags latch and clear at each tick without loss or double count.
// [RULE_16] The far peer fills its remote indications from its own sink results.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Payload buffer: flip-flop FIFO with valid and ready on both sides
module ttm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rstN,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } ttm_fifo_state_t;

  ttm_fifo_state_t s;
  ttm_fifo_state_t next_s;
  logic doWrite;
  logic doRead;

  // Handshakes and honest full and empty
  assign inReady = (s.count != (AW+1)'(DEPTH));
  assign outValid = (s.count != '0);
  assign outData = s.mem[s.rdPtr];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  // Pointer and occupancy update
  always_comb begin
    next_s = s;
    if (doWrite) begin
      next_s.mem[s.wrPtr] = inData;
      next_s.wrPtr = s.wrPtr + 1'b1;
    end
    if (doRead) begin
      next_s.rdPtr = s.rdPtr + 1'b1;
    end
    if (doWrite && !doRead) begin
      next_s.count = s.count + 1'b1;
    end else if (doRead && !doWrite) begin
      next_s.count = s.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : ttm_fifo

////////////////////////////////////////////////////////////////////////////////
// Top: source overhead insertion, sink supervision, per-second performance
module ttm_monitor (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic physSectionMode,
  input wire logic [7:0] localPathId,
  input wire logic [7:0] expectedPathId,
  input wire logic oneSecTick,
  input wire logic [7:0] srcData,
  input wire logic srcValid,
  output logic srcReady,
  input wire logic txSlot,
  output logic [7:0] txData,
  output logic txValid,
  output logic txFrameStart,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic rxFrameStart,
  input wire logic signalLossPin,
  output logic [7:0] rxOut,
  output logic rxOutValid,
  output logic signalLoss,
  output logic serverFail,
  output logic pathMismatch,
  output logic farDefect,
  output logic nearBitError,
  output logic [19:0] nearBlockSec,
  output logic [19:0] farBlockSec,
  output logic nearDefectSec,
  output logic farDefectSec,
  output logic erroredSecond,
  output logic severelyErroredSecond,
  output logic unavailableSecond,
  output logic farErroredSecond,
  output logic secondReport
);

  typedef struct packed {
    logic losMeta;
    logic losSync;
    logic [3:0] txPos;
    logic [7:0] txParity;
    logic [7:0] txParityHold;
    logic [7:0] txData;
    logic txValid;
    logic txFrameStart;
    logic [3:0] rxPos;
    logic rxPrimed;
    logic [7:0] rxParity;
    logic [7:0] rxParityHold;
    logic rxAllOnes;
    logic [3:0] frameErrCount;
    logic nearBitError;
    logic serverFail;
    logic pathMismatch;
    logic farDefect;
    logic defect;
    logic [7:0] rxOut;
    logic rxOutValid;
    logic [19:0] nearCnt;
    logic [19:0] farCnt;
    logic nearDefSec;
    logic farDefSec;
    logic [19:0] nearBlockSec;
    logic [19:0] farBlockSec;
    logic nearDefectSec;
    logic farDefectSec;
    logic erroredSecond;
    logic severelyErroredSecond;
    logic unavailable;
    logic farErroredSecond;
    logic [3:0] sesRun;
    logic [3:0] clrRun;
    logic secondReport;
  } ttm_state_t;

  ttm_state_t s;
  ttm_state_t next_s;
  logic [1:0] rstSync;
  logic rstN;
  logic [7:0] fifoData;
  logic fifoValid;
  logic fifoReady;

  // Count of set bits, used for parity violation counts
  function automatic logic [3:0] ttm_ones(input logic [7:0] v);
    logic [3:0] n;
    n = '0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'b000, v[i]};
    end
    return n;
  endfunction : ttm_ones

  // Reset release through two flip-flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // Client payload buffer, drained only in payload slots
  ttm_fifo #(.WIDTH(ttm_pkg::BYTE_W), .DEPTH(ttm_pkg::FIFO_DEPTH)) payloadFifo (
    .mclk(mclk),
    .rstN(rstN),
    .inData(srcData),
    .inValid(srcValid),
    .inReady(srcReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoReady)
  );

  // Payload slot: every slot in physical mode, past the overhead otherwise
  assign fifoReady = txSlot && (physSectionMode || (s.txPos >= ttm_pkg::POS_PAYLOAD)); // see [RULE_14]

  // Next-state logic of the whole block
  always_comb begin
    logic [7:0] txByte;
    logic [3:0] viol;
    logic nearInc;
    logic farInc;
    logic sigFail;
    logic severely_errored_second;
    txByte = ttm_pkg::IDLE_BYTE;
    viol = '0;
    nearInc = 1'b0;
    farInc = 1'b0;
    sigFail = 1'b0;
    severely_errored_second = 1'b0;
    next_s = s;

    // Loss pin synchroniser
    next_s.losMeta = signalLossPin;
    next_s.losSync = s.losMeta; // see [RULE_04]

    // Source direction: overhead insertion and payload
    next_s.txValid = txSlot;
    next_s.txFrameStart = txSlot && (s.txPos == '0);
    if (txSlot) begin
      if (fifoValid && fifoReady) begin
        txByte = fifoData;
      end
      if (!physSectionMode) begin
        case (s.txPos)
          ttm_pkg::POS_PARITY: txByte = s.txParityHold; // see [RULE_01]
          ttm_pkg::POS_PATH: txByte = localPathId; // see [RULE_01]
          ttm_pkg::POS_REMOTE: begin
            txByte = '0;
            txByte[ttm_pkg::REMOTE_DEFECT_BIT] = s.defect; // see [RULE_03] [RULE_07]
            txByte[ttm_pkg::REMOTE_COUNT_MSB:0] = s.frameErrCount; // see [RULE_02]
          end
          default: txByte = txByte;
        endcase
      end
      next_s.txData = txByte;
      next_s.txPos = (s.txPos == ttm_pkg::FRAME_LAST) ? '0 : s.txPos + 1'b1;
      if (s.txPos == ttm_pkg::FRAME_LAST) begin
        next_s.txParityHold = s.txParity ^ txByte;
        next_s.txParity = '0;
      end else begin
        next_s.txParity = s.txParity ^ txByte;
      end
    end

    // Sink direction: frame position, parity, identifier, remote fields
    if (rxValid) begin
      next_s.rxPos = rxFrameStart ? 4'h1 : s.rxPos + 1'b1;
      if (rxFrameStart || s.rxPos == '0) begin
        // Parity byte closes the previous frame's check
        next_s.rxParity = rxData;
        next_s.rxAllOnes = (rxData == ttm_pkg::ALL_ONES);
        if (s.rxPrimed && !physSectionMode) begin
          viol = ttm_ones(rxData ^ s.rxParityHold); // see [RULE_05]
          next_s.frameErrCount = viol; // see [RULE_02]
          nearInc = (viol != '0); // see [RULE_09]
        end
      end else begin
        next_s.rxParity = s.rxParity ^ rxData;
        next_s.rxAllOnes = s.rxAllOnes && (rxData == ttm_pkg::ALL_ONES);
        if (!physSectionMode && s.rxPos == ttm_pkg::POS_PATH) begin
          next_s.pathMismatch = (rxData != expectedPathId); // see [RULE_06]
        end
        if (!physSectionMode && s.rxPos == ttm_pkg::POS_REMOTE) begin
          next_s.farDefect = rxData[ttm_pkg::REMOTE_DEFECT_BIT]; // see [RULE_04] [RULE_16]
          farInc = (rxData[ttm_pkg::REMOTE_COUNT_MSB:0] != '0); // see [RULE_10]
        end
        if (s.rxPos == ttm_pkg::FRAME_LAST) begin
          next_s.rxParityHold = s.rxParity ^ rxData;
          next_s.rxPrimed = 1'b1;
          next_s.serverFail = s.rxAllOnes && (rxData == ttm_pkg::ALL_ONES); // see [RULE_04]
          next_s.rxPos = '0;
        end
      end
    end
    next_s.nearBitError = nearInc; // see [RULE_08]

    // Physical section mode drops all but loss supervision
    if (physSectionMode) begin
      next_s.pathMismatch = 1'b0; // see [RULE_14]
      next_s.farDefect = 1'b0;
      next_s.frameErrCount = '0;
      next_s.serverFail = 1'b0;
    end

    // Defect state, fail signal substitution
    sigFail = s.losSync || s.serverFail || s.pathMismatch;
    next_s.defect = sigFail; // see [RULE_07]
    next_s.rxOut = s.defect ? ttm_pkg::ALL_ONES : rxData; // see [RULE_07]
    next_s.rxOutValid = rxValid;

    // Per-second accumulation; events in the tick cycle open the new second
    next_s.secondReport = oneSecTick;
    if (oneSecTick) begin
      next_s.nearBlockSec = s.nearCnt; // see [RULE_15]
      next_s.farBlockSec = s.farCnt;
      next_s.nearDefectSec = s.nearDefSec;
      next_s.farDefectSec = s.farDefSec;
      next_s.nearCnt = {19'h00000, nearInc};
      next_s.farCnt = {19'h00000, farInc};
      next_s.nearDefSec = sigFail; // see [RULE_11]
      next_s.farDefSec = s.farDefect; // see [RULE_12]
      severely_errored_second = s.nearDefSec || (s.nearCnt >= ttm_pkg::SES_THRESHOLD); // see [RULE_13]
      next_s.erroredSecond = s.nearDefSec || (s.nearCnt != '0); // see [RULE_13]
      next_s.severelyErroredSecond = severely_errored_second;
      next_s.farErroredSecond = s.farDefSec || (s.farCnt != '0);
      // Unavailable entry and exit after runs of severe or non-severe seconds
      if (severely_errored_second) begin
        next_s.clrRun = '0;
        if (s.sesRun != ttm_pkg::UAS_ENTER) begin
          next_s.sesRun = s.sesRun + 1'b1;
        end
        if (s.sesRun + 1'b1 >= ttm_pkg::UAS_ENTER) begin
          next_s.unavailable = 1'b1; // see [RULE_13]
        end
      end else begin
        next_s.sesRun = '0;
        if (s.clrRun != ttm_pkg::UAS_EXIT) begin
          next_s.clrRun = s.clrRun + 1'b1;
        end
        if (s.clrRun + 1'b1 >= ttm_pkg::UAS_EXIT) begin
          next_s.unavailable = 1'b0;
        end
      end
    end else begin
      if (nearInc && s.nearCnt != '1) begin
        next_s.nearCnt = s.nearCnt + 1'b1; // see [RULE_09]
      end
      if (farInc && s.farCnt != '1) begin
        next_s.farCnt = s.farCnt + 1'b1; // see [RULE_10]
      end
      next_s.nearDefSec = s.nearDefSec || sigFail; // see [RULE_11]
      next_s.farDefSec = s.farDefSec || s.farDefect; // see [RULE_12]
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state
  assign txData = s.txData;
  assign txValid = s.txValid;
  assign txFrameStart = s.txFrameStart;
  assign rxOut = s.rxOut;
  assign rxOutValid = s.rxOutValid;
  assign signalLoss = s.losSync; // see [RULE_08]
  assign serverFail = s.serverFail;
  assign pathMismatch = s.pathMismatch;
  assign farDefect = s.farDefect;
  assign nearBitError = s.nearBitError;
  assign nearBlockSec = s.nearBlockSec;
  assign farBlockSec = s.farBlockSec;
  assign nearDefectSec = s.nearDefectSec;
  assign farDefectSec = s.farDefectSec;
  assign erroredSecond = s.erroredSecond;
  assign severelyErroredSecond = s.severelyErroredSecond;
  assign unavailableSecond = s.unavailable;
  assign farErroredSecond = s.farErroredSecond;
  assign secondReport = s.secondReport;

endmodule : ttm_monitor

// file: src/ttm_pkg.sv
// Shared constants of the trail termination monitor
package ttm_pkg;

  // Stream byte width and position of the last byte in a frame
  localparam int BYTE_W = 8;
  localparam logic [3:0] FRAME_LAST = 4'hf;

  // Overhead byte positions inside a frame
  localparam logic [3:0] POS_PARITY = 4'h0;
  localparam logic [3:0] POS_PATH = 4'h1;
  localparam logic [3:0] POS_REMOTE = 4'h2;
  localparam logic [3:0] POS_PAYLOAD = 4'h3;

  // Field layout of the remote indication byte
  localparam int REMOTE_DEFECT_BIT = 7;
  localparam int REMOTE_COUNT_MSB = 3;

  // Fail signal pattern and idle payload filler
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] IDLE_BYTE = 8'h00;

  // Per-second counter width and severe threshold in errored blocks
  localparam int SEC_CNT_W = 20;
  localparam logic [19:0] SES_THRESHOLD = 20'h0001e;

  // Consecutive seconds to enter and leave the unavailable state
  localparam logic [3:0] UAS_ENTER = 4'ha;
  localparam logic [3:0] UAS_EXIT = 4'ha;

  // Source payload buffer shape
  localparam int FIFO_DEPTH = 16;

endpackage : ttm_pkg

// file: tb/ttm_monitor_sva.sv
// Port-level assertions for the trail termination monitor
`timescale 1ns/1ps
module ttm_monitor_sva (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic oneSecTick,
  input wire logic txSlot,
  input wire logic txValid,
  input wire logic [7:0] rxOut,
  input wire logic rxOutValid,
  input wire logic signalLoss,
  input wire logic serverFail,
  input wire logic pathMismatch,
  input wire logic [19:0] nearBlockSec,
  input wire logic nearDefectSec,
  input wire logic erroredSecond,
  input wire logic severelyErroredSecond,
  input wire logic secondReport
);
  // All checks share one clock and its reset
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  property p_tx_take;
    txSlot |=> txValid;
  endproperty
  a_tx_take: assert property (p_tx_take) else $error("slot gave no byte");
  property p_tx_idle;
    !txSlot |=> !txValid;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("byte without slot");
  property p_report;
    oneSecTick |=> secondReport;
  endproperty
  a_report: assert property (p_report) else $error("report missing");
  property p_no_report;
    !oneSecTick |=> !secondReport;
  endproperty
  a_no_report: assert property (p_no_report) else $error("stray report");
  // A defect that has stood three cycles must show as all ones
  property p_fail_ones;
    (signalLoss || serverFail || pathMismatch)[*3] ##0 rxOutValid |-> rxOut == 8'hff;
  endproperty
  a_fail_ones: assert property (p_fail_ones) else $error("no fail pattern");
  property p_es;
    (nearDefectSec || nearBlockSec != 20'h00000) |-> erroredSecond;
  endproperty
  a_es: assert property (p_es) else $error("errored second missing");
  property p_ses;
    (nearDefectSec || nearBlockSec >= ttm_pkg::SES_THRESHOLD) |-> severelyErroredSecond;
  endproperty
  a_ses: assert property (p_ses) else $error("severe second missing");
  property p_hold;
    ($changed(nearBlockSec) || $changed(nearDefectSec)) |-> secondReport;
  endproperty
  a_hold: assert property (p_hold) else $error("count moved mid second");
  // Main scenarios
  c_fail: cover property (serverFail && rxOutValid);
  c_path: cover property (pathMismatch);
  c_ses: cover property (secondReport ##1 severelyErroredSecond);
endmodule : ttm_monitor_sva

// file: tb/ttm_monitor_tb_top.sv
// Self-checking bench for the trail termination monitor
`timescale 1ns/1ps
module ttm_monitor_tb_top;
  logic mclk = 1'b0, reset_n = 1'b0, phys = 1'b0, tick = 1'b0, srcValid = 1'b0;
  logic txSlot = 1'b0, lossPin = 1'b0, defBit = 1'b0, allOnes = 1'b0, run = 1'b0;
  logic [7:0] locId = 8'h00, expId = 8'h00, pathId = 8'h00, flip = 8'h00, srcData = 8'h00;
  logic [7:0] txRemote = 8'h00, par, rxData, rxOut, txData;
  logic [3:0] errCnt = 4'h0, txPos = 4'h0;
  logic [31:0] seed = 32'h00000006;
  logic rxValid, rxFs, srcReady, txValid, txFs, sigLoss, srvFail, pathBad, farDef;
  logic [19:0] nearBlk, farBlk;
  logic nds, fds, es, severely_errored_second, unavailable_second, fes;
  logic nbe, rxOv;
  int nbeSeen = 0;
  logic [7:0] txQ[$], srcQ[$];
  int errTotal = 0, samplesChecked = 0;
  ////////////////////////////////////////////////////////////
  // 10 MHz clock
  always #50 mclk = ~mclk;
  ttm_monitor dut (.mclk(mclk), .reset_n(reset_n), .physSectionMode(phys),
    .localPathId(locId), .expectedPathId(expId), .oneSecTick(tick), .srcData(srcData),
    .srcValid(srcValid), .srcReady(srcReady), .txSlot(txSlot), .txData(txData),
    .txValid(txValid), .txFrameStart(txFs), .rxData(rxData), .rxValid(rxValid),
    .rxFrameStart(rxFs), .signalLossPin(lossPin), .rxOut(rxOut), .rxOutValid(rxOv),
    .signalLoss(sigLoss), .serverFail(srvFail), .pathMismatch(pathBad), .farDefect(farDef),
    .nearBitError(nbe), .nearBlockSec(nearBlk), .farBlockSec(farBlk), .nearDefectSec(nds),
    .farDefectSec(fds), .erroredSecond(es), .severelyErroredSecond(severely_errored_second),
    .unavailableSecond(unavailable_second), .farErroredSecond(fes), .secondReport());
  ttm_peer peer (.mclk(mclk), .run(run), .pathId(pathId), .parityFlip(flip), .defBit(defBit),
    .errCount(errCnt), .allOnes(allOnes), .rxData(rxData), .rxValid(rxValid), .rxFrameStart(rxFs));
  // Record outgoing bytes, check frame starts, keep the latest remote byte, count error pulses
  always @(posedge mclk) begin
    if (nbe === 1'b1) nbeSeen++;
    if (txValid === 1'b1) begin
      check(txFs, (txQ.size() % 16) == 0);
      txQ.push_back(txData);
      txPos = (txFs === 1'b1) ? 4'h0 : txPos + 4'h1;
      if (txPos == 4'h2) txRemote = txData;
    end
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  // Expected outgoing byte i, given parity of the previous frame
  function automatic logic [7:0] expTx(input int i, input logic [7:0] p);
    int idx;
    idx = (i / 16) * 13 + (i % 16) - 3;
    case (i % 16)
      0: return p;
      1: return locId;
      2: return 8'h00;
      default: return (idx < 16) ? srcQ[idx] : 8'h00;
    endcase
  endfunction : expTx
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask : step
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic endSim();
    $display("checks=%0d mismatches=%0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : endSim
  task automatic pulseTick();
    tick = 1'b1;
    step(1);
    tick = 1'b0;
    step(1);
  endtask : pulseTick
  // One second of peer traffic with the given faults, then its report
  task automatic runSecond(input logic [7:0] f, input logic [3:0] c, input logic d,
      input logic o, input int n);
    int k;
    k = 0;
    while (rxFs !== 1'b1 && k < 40) begin
      step(1);
      k++;
    end
    if (k == 40) begin
      errTotal++;
      endSim();
    end
    flip = f;
    errCnt = c;
    defBit = d;
    allOnes = o;
    pulseTick();
    nbeSeen = 0;
    step(16 * n - 2);
    check(srvFail, o);
    check(txRemote[7], o);
    if (f != 8'h00) check(txRemote[3:0], 4'($countones(f)));
    if (!o) check(farDef, d);
    flip = 8'h00;
    errCnt = 4'h0;
    defBit = 1'b0;
    allOnes = 1'b0;
    step(40);
    pulseTick();
    check(nds, o);
    check(es, o | (f != 8'h00));
    check(severely_errored_second, o | (f != 8'h00 && n >= ttm_pkg::SES_THRESHOLD));
    if (!o) begin
      check(nearBlk, (f != 8'h00) ? n : 0);
      check(nbeSeen, (f != 8'h00) ? n : 0);
      check(farBlk, (c != 4'h0) ? n : 0);
      check(fds, d);
      check(fes, d | (c != 4'h0));
    end
  endtask : runSecond
  // Main sequence
  initial begin
    locId = rnd();
    expId = rnd();
    pathId = expId;
    step(12);
    reset_n = 1'b1;
    step(3);
    for (int i = 0; i < 18; i++) begin
      srcData = rnd();
      srcValid = 1'b1;
      if (srcReady) srcQ.push_back(srcData);
      step(1);
    end
    srcValid = 1'b0;
    check(srcQ.size(), 16);
    txSlot = 1'b1;
    step(50);
    par = 8'h00;
    for (int i = 0; i < 48; i++) begin
      if (i >= 16 || i % 16 != 0) check(txQ[i], expTx(i, par));
      par = (i % 16 == 0) ? txQ[i] : par ^ txQ[i];
    end
    check(srcReady, 1'b1);
    run = 1'b1;
    step(40);
    check(pathBad, 1'b0);
    check(rxOv, 1'b1);
    runSecond(rnd() | 8'h01, 4'h0, 1'b0, 1'b0, 3);
    runSecond(8'h00, 4'(rnd()) | 4'h1, 1'b0, 1'b0, 2);
    runSecond(8'h00, 4'h0, 1'b1, 1'b0, 2);
    runSecond(rnd() | 8'h01, 4'h0, 1'b0, 1'b0, 29);
    runSecond(rnd() | 8'h01, 4'h0, 1'b0, 1'b0, 30);
    // Four frames so a remote byte sent after the defect is surely seen
    runSecond(8'h00, 4'h0, 1'b0, 1'b1, 4);
    pathId = ~expId;
    step(48);
    check(pathBad, 1'b1);
    check(rxOut, 8'hff);
    check(txRemote[7], 1'b1);
    phys = 1'b1;
    step(48);
    check(pathBad, 1'b0);
    for (int i = 1; i <= 16; i++) check(txQ[txQ.size() - i], 8'h00);
    lossPin = 1'b1;
    step(6);
    check(sigLoss, 1'b1);
    step(3);
    check(rxOut, 8'hff);
    lossPin = 1'b0;
    phys = 1'b0;
    pathId = expId;
    step(48);
    check(sigLoss, 1'b0);
    pulseTick();
    step(60);
    pulseTick();
    allOnes = 1'b1;
    for (int k = 1; k <= 21; k++) begin
      if (k == 11) allOnes = 1'b0;
      step(60);
      pulseTick();
      step(2);
      check(unavailable_second, (k >= 10 && k <= 20));
    end
    endSim();
  end
endmodule : ttm_monitor_tb_top
bind ttm_monitor ttm_monitor_sva u_sva (.mclk(mclk), .reset_n(reset_n), .oneSecTick(oneSecTick),
  .txSlot(txSlot), .txValid(txValid), .rxOut(rxOut), .rxOutValid(rxOutValid),
  .signalLoss(signalLoss), .serverFail(serverFail), .pathMismatch(pathMismatch),
  .nearBlockSec(nearBlockSec), .nearDefectSec(nearDefectSec), .erroredSecond(erroredSecond),
  .severelyErroredSecond(severelyErroredSecond), .secondReport(secondReport));

// file: tb/ttm_peer.sv
// Far-end peer model sending framed traffic built from the settings the bench drives
`timescale 1ns/1ps
module ttm_peer (
  input wire logic mclk,
  input wire logic run,
  input wire logic [7:0] pathId,
  input wire logic [7:0] parityFlip,
  input wire logic defBit,
  input wire logic [3:0] errCount,
  input wire logic allOnes,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxFrameStart
);
  logic [3:0] pos = 4'h0;
  logic [7:0] acc = 8'h00;
  logic [7:0] fill = 8'h5a;
  logic [7:0] b;
  logic [21:0] cfg = 22'h000000;
  ////////////////////////////////////////////////////////////
  // Idle line at start
  initial begin
    rxData = 8'h00;
    rxValid = 1'b0;
    rxFrameStart = 1'b0;
  end
  // One byte a cycle; settings taken at byte 0 hold for the whole frame
  always @(posedge mclk) begin
    if (!run) begin
      rxValid <= 1'b0;
      rxFrameStart <= 1'b0;
      rxData <= ~rxData; // Released line toggles, never holds
      pos <= 4'h0;
    end else begin
      if (pos == 4'h0) cfg = {pathId, parityFlip, defBit, errCount, allOnes};
      case (pos)
        4'h0: b = acc ^ cfg[13:6];
        4'h1: b = cfg[21:14];
        4'h2: b = {cfg[5], 3'b000, cfg[4:1]};
        default: b = fill;
      endcase
      if (cfg[0]) b = 8'hff;
      acc = (pos == 4'h0) ? b : acc ^ b;
      fill <= fill + 8'h3b;
      rxData <= b;
      rxValid <= 1'b1;
      rxFrameStart <= (pos == 4'h0);
      pos <= pos + 4'h1;
    end
  end
endmodule : ttm_peer
